/* File: rtl/spg_pkg.sv */
// constants and carrier types of the sleep and power gating controller
package spg_pkg;
    // ==========================================================
    // register map (byte offsets of the plain register port)
    localparam logic [7:0] CORE_CONTROL_REG_ADDR = 8'h00;
    localparam logic [7:0] MODULE_CLOCK_GATE_REG_ADDR = 8'h01;
    localparam logic [7:0] SLEEP_STATUS_REG_ADDR = 8'h02;
    // ==========================================================
    // core control fields
    localparam int BROWNOUT_SLEEP_OFF_BIT_OFF_BIT = 7;
    localparam int SLEEP_ENABLE_BIT = 5;
    localparam int SLEEP_MODE_LSB = 3;
    localparam int BROWNOUT_SLEEP_OFF_BIT_UNLOCK_BIT = 2;
    localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;
    // ==========================================================
    // module clock gate fields
    localparam int GATE_FAST_TIMER_BIT = 3;
    localparam int GATE_BASIC_TIMER_BIT = 2;
    localparam int GATE_SERIAL_UNIT_BIT = 1;
    localparam int GATE_CONVERTER_BIT = 0;
    localparam logic [3:0] MODULE_CLOCK_GATE_RESET = 4'h0;
    // ==========================================================
    // status fields
    localparam int STAT_SLEEPING_BIT = 0;
    localparam int STAT_WAKING_BIT = 1;
    localparam int STAT_BOD_OFF_BIT = 2;
    localparam int STAT_MODE_LSB = 4;
    // ==========================================================
    // sleep mode encodings
    localparam logic [1:0] SLEEP_MODE_IDLE = 2'h0;
    localparam logic [1:0] SLEEP_MODE_ADC_NR = 2'h1;
    localparam logic [1:0] SLEEP_MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] SLEEP_MODE_RESERVED = 2'h3;
    // ==========================================================
    // timing
    localparam int TIMER_W = 12;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int UNLOCK_WINDOW_CYCLES = 4;
    localparam int BROWNOUT_SLEEP_OFF_BIT_SETTLE_CYCLES = 3;
    localparam int BROWNOUT_SLEEP_OFF_BIT_HOLD_CYCLES = 3;
    localparam int WAKE_HALT_CYCLES = 4;
    localparam int RESET_WAKE_US = 64;
    localparam int RESET_WAKE_CYCLES =
        (RESET_WAKE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_WAKE_START,
        ST_WAKE_HALT
    } spg_state_e;

    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic adc;
        logic fast;
        logic osc;
    } spg_clk_s;

    typedef struct packed {
        logic fastTimer;
        logic basicTimer;
        logic serialUnit;
        logic converter;
    } spg_periph_s;

    typedef struct packed {
        logic extIrqLevel;
        logic extIrqEdge;
        logic pinChange;
        logic memReady;
        logic serialStart;
        logic adcDone;
        logic otherIo;
        logic watchdogIrq;
    } spg_wake_s;
endpackage

/* File: rtl/spg_cycle_timer.sv */
// one-shot cycle timer used for windows, delays and halts
`timescale 1ns/1ps
module spg_cycle_timer
    import spg_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] loadVal,
    output logic running,
    output logic done
);
    logic [W-1:0] count_q;

    // a start while running is ignored: a window is never stretched
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (running) begin
                if (count_q == W'(1)) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
                count_q <= count_q - W'(1);
            end else if (start) begin
                count_q <= loadVal;
                running <= 1'b1;
            end
        end
    end
endmodule

/* File: rtl/spg_sleep_ctrl.sv */
// sleep mode, wake-up, brown-out sleep-off and module clock gate control
`timescale 1ns/1ps
module spg_sleep_ctrl
    import spg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic sleepInstr,
    input wire spg_wake_s wakeReq,
    input wire logic adcEnabled,
    input wire logic oscStable,
    output logic [7:0] busRdData_q,
    output spg_clk_s clkEn_q,
    output spg_periph_s periphEn_q,
    output logic bodEnable_q,
    output logic adcStart_q,
    output logic coreHalt_q,
    output logic resumeIrq_q,
    output logic resetVector_q
);
    // ==========================================================
    // register file
    logic sleepEnable_q;
    logic [1:0] sleepMode_q;
    logic [3:0] gate_q;
    logic ctrlWr;
    logic armWr;
    logic unlockWr;

    assign ctrlWr = busWr && (busAddr == CORE_CONTROL_REG_ADDR);
    assign unlockWr = ctrlWr && busWrData[BROWNOUT_SLEEP_OFF_BIT_OFF_BIT]
        && busWrData[BROWNOUT_SLEEP_OFF_BIT_UNLOCK_BIT];
    assign armWr = ctrlWr && busWrData[BROWNOUT_SLEEP_OFF_BIT_OFF_BIT]
        && !busWrData[BROWNOUT_SLEEP_OFF_BIT_UNLOCK_BIT];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleepEnable_q <= CORE_CONTROL_RESET[SLEEP_ENABLE_BIT];
            sleepMode_q <= CORE_CONTROL_RESET[SLEEP_MODE_LSB +: 2];
        end else if (ctrlWr) begin
            sleepEnable_q <= busWrData[SLEEP_ENABLE_BIT];
            sleepMode_q <= busWrData[SLEEP_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_q <= MODULE_CLOCK_GATE_RESET;
        end else if (busWr && (busAddr == MODULE_CLOCK_GATE_REG_ADDR)) begin
            gate_q <= busWrData[3:0];
        end
    end

    // ==========================================================
    // brown-out sleep-off timed sequence
    logic unlockOpen;
    logic settleDone;
    logic bodsActive;

    // the first write opens a window; only a second write inside it arms
    spg_cycle_timer u_unlock (
        .clock(clock),
        .rst(rst),
        .start(unlockWr),
        .loadVal(TIMER_W'(UNLOCK_WINDOW_CYCLES)),
        .running(unlockOpen),
        .done()
    );

    spg_cycle_timer u_settle (
        .clock(clock),
        .rst(rst),
        .start(armWr && unlockOpen),
        .loadVal(TIMER_W'(BROWNOUT_SLEEP_OFF_BIT_SETTLE_CYCLES)),
        .running(),
        .done(settleDone)
    );

    spg_cycle_timer u_hold (
        .clock(clock),
        .rst(rst),
        .start(settleDone),
        .loadVal(TIMER_W'(BROWNOUT_SLEEP_OFF_BIT_HOLD_CYCLES)),
        .running(bodsActive),
        .done()
    );

    // ==========================================================
    // sleep state machine
    spg_state_e state_q;
    spg_state_e state_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic bodOff_q;
    logic bodOff_d;
    logic sleepGo;
    logic wakeHit;
    logic resetWait_q;
    logic resetWaitDone;
    logic haltDone;
    logic enterHalt;

    // the reserved field value leaves the instruction without effect
    assign sleepGo = sleepInstr && sleepEnable_q
        && (sleepMode_q != SLEEP_MODE_RESERVED);

    always_comb begin
        case (mode_q)
            SLEEP_MODE_IDLE: wakeHit = |wakeReq;
            SLEEP_MODE_ADC_NR: wakeHit = wakeReq.adcDone
                || wakeReq.memReady || wakeReq.pinChange
                || wakeReq.extIrqLevel;
            SLEEP_MODE_POWER_DOWN: wakeHit = wakeReq.serialStart
                || wakeReq.pinChange || wakeReq.watchdogIrq
                || wakeReq.extIrqLevel;
            default: wakeHit = 1'b0;
        endcase
    end

    // oscillator restart and, after a detector-off sleep, the reset delay
    assign enterHalt = (state_q == ST_WAKE_START) && oscStable
        && !resetWait_q;

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        bodOff_d = bodOff_q;
        case (state_q)
            ST_ACTIVE: begin
                if (sleepGo) begin
                    state_d = ST_SLEEP;
                    mode_d = sleepMode_q;
                    bodOff_d = bodsActive
                        && (sleepMode_q == SLEEP_MODE_POWER_DOWN);
                end
            end
            ST_SLEEP: begin
                if (wakeHit) begin
                    state_d = ST_WAKE_START;
                end
            end
            ST_WAKE_START: begin
                if (enterHalt) begin
                    state_d = ST_WAKE_HALT;
                    bodOff_d = 1'b0;
                end
            end
            ST_WAKE_HALT: begin
                if (haltDone) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: state_d = ST_ACTIVE;
        endcase
    end

    // reset drops straight to active; nothing here touches core storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_ACTIVE;
            mode_q <= SLEEP_MODE_IDLE;
            bodOff_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            bodOff_q <= bodOff_d;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resetWait_q <= 1'b0;
        end else if (state_q == ST_SLEEP && wakeHit && bodOff_q) begin
            resetWait_q <= 1'b1;
        end else if (resetWaitDone) begin
            resetWait_q <= 1'b0;
        end
    end

    spg_cycle_timer u_reset_wake (
        .clock(clock),
        .rst(rst),
        .start(state_q == ST_SLEEP && wakeHit && bodOff_q),
        .loadVal(TIMER_W'(RESET_WAKE_CYCLES)),
        .running(),
        .done(resetWaitDone)
    );

    // loaded one short: the done cycle is the last halted cycle
    spg_cycle_timer u_halt (
        .clock(clock),
        .rst(rst),
        .start(enterHalt),
        .loadVal(TIMER_W'(WAKE_HALT_CYCLES - 1)),
        .running(),
        .done(haltDone)
    );

    // ==========================================================
    // clock enables, registered from the next state
    spg_clk_s clk_d;

    always_comb begin
        clk_d = '{core: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
                  fast: 1'b1, osc: 1'b1};
        if (state_d == ST_SLEEP) begin
            case (mode_d)
                SLEEP_MODE_IDLE: begin
                    clk_d.core = 1'b0;
                    clk_d.flash = 1'b0;
                end
                SLEEP_MODE_ADC_NR: begin
                    clk_d = '{core: 1'b0, flash: 1'b0, io: 1'b0,
                              adc: 1'b1, fast: 1'b0, osc: 1'b1};
                end
                default: clk_d = '0;
            endcase
        end else if (state_d != ST_ACTIVE) begin
            // core stays frozen until the halt ends
            clk_d.core = 1'b0;
            clk_d.flash = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkEn_q <= '1;
            periphEn_q <= '1;
        end else begin
            clkEn_q <= clk_d;
            // gating also blocks register access of that peripheral
            periphEn_q.fastTimer <= clk_d.fast
                && !gate_q[GATE_FAST_TIMER_BIT];
            periphEn_q.basicTimer <= clk_d.io
                && !gate_q[GATE_BASIC_TIMER_BIT];
            periphEn_q.serialUnit <= clk_d.io
                && !gate_q[GATE_SERIAL_UNIT_BIT];
            periphEn_q.converter <= clk_d.adc
                && !gate_q[GATE_CONVERTER_BIT];
        end
    end

    // ==========================================================
    // core side and detector outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bodEnable_q <= 1'b1;
            adcStart_q <= 1'b0;
            coreHalt_q <= 1'b0;
            resumeIrq_q <= 1'b0;
            resetVector_q <= 1'b1;
        end else begin
            bodEnable_q <= !(bodOff_d && state_d != ST_ACTIVE);
            adcStart_q <= sleepGo && (state_q == ST_ACTIVE) && adcEnabled
                && (sleepMode_q != SLEEP_MODE_POWER_DOWN);
            coreHalt_q <= (state_d != ST_ACTIVE);
            resumeIrq_q <= (state_q == ST_WAKE_HALT) && haltDone;
            resetVector_q <= 1'b0;
        end
    end

    // ==========================================================
    // read port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busRdData_q <= 8'h00;
        end else if (busRd) begin
            case (busAddr)
                CORE_CONTROL_REG_ADDR: begin
                    busRdData_q <= 8'h00;
                    busRdData_q[BROWNOUT_SLEEP_OFF_BIT_OFF_BIT] <= bodsActive;
                    busRdData_q[SLEEP_ENABLE_BIT] <= sleepEnable_q;
                    busRdData_q[SLEEP_MODE_LSB +: 2] <= sleepMode_q;
                    busRdData_q[BROWNOUT_SLEEP_OFF_BIT_UNLOCK_BIT] <= unlockOpen;
                end
                MODULE_CLOCK_GATE_REG_ADDR: busRdData_q <= {4'h0, gate_q};
                SLEEP_STATUS_REG_ADDR: begin
                    busRdData_q <= 8'h00;
                    busRdData_q[STAT_SLEEPING_BIT] <= (state_q == ST_SLEEP);
                    busRdData_q[STAT_WAKING_BIT] <= (state_q == ST_WAKE_START)
                        || (state_q == ST_WAKE_HALT);
                    busRdData_q[STAT_BOD_OFF_BIT] <= bodOff_q;
                    busRdData_q[STAT_MODE_LSB +: 2] <= mode_q;
                end
                default: busRdData_q <= 8'h00;
            endcase
        end else begin
            busRdData_q <= 8'h00;
        end
    end

    // ==========================================================
    // assertions
    a_sleep_needs_enable:
    assert property (@(posedge clock) disable iff (rst)
        $rose(coreHalt_q) |-> $past(sleepInstr && sleepEnable_q))
        else $error("sleep entered without enable and instruction");

    a_idle_clocks:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_SLEEP && mode_q == SLEEP_MODE_IDLE)
        |-> !clkEn_q.core && !clkEn_q.flash && clkEn_q.io && clkEn_q.osc)
        else $error("idle clock set wrong");

    a_noise_clocks:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_SLEEP && mode_q == SLEEP_MODE_ADC_NR)
        |-> !clkEn_q.io && !clkEn_q.core && clkEn_q.adc && clkEn_q.osc)
        else $error("noise mode clock set wrong");

    a_pdown_clocks:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_SLEEP && mode_q == SLEEP_MODE_POWER_DOWN)
        |-> clkEn_q == '0)
        else $error("power-down clocks not all stopped");

    a_halt_four:
    assert property (@(posedge clock) disable iff (rst)
        $rose(state_q == ST_WAKE_HALT)
        |-> (state_q == ST_WAKE_HALT)[*4] ##1 state_q == ST_ACTIVE)
        else $error("wake halt not four cycles");

    a_pdown_sources:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_SLEEP && mode_q == SLEEP_MODE_POWER_DOWN
         && !wakeReq.serialStart && !wakeReq.pinChange
         && !wakeReq.watchdogIrq && !wakeReq.extIrqLevel)
        |=> state_q == ST_SLEEP)
        else $error("power-down woken by a foreign source");

    a_adc_autostart:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_ACTIVE && sleepGo && adcEnabled
         && sleepMode_q != SLEEP_MODE_POWER_DOWN) |=> adcStart_q)
        else $error("conversion not started on sleep entry");

    a_bod_off_pdown:
    assert property (@(posedge clock) disable iff (rst)
        !bodEnable_q |-> (mode_q == SLEEP_MODE_POWER_DOWN)
        && (state_q == ST_SLEEP || state_q == ST_WAKE_START))
        else $error("detector off outside power-down");

    a_brownout_sleep_off_bit_life:
    assert property (@(posedge clock) disable iff (rst)
        $rose(bodsActive) |-> bodsActive[*3] ##1 !bodsActive)
        else $error("sleep-off bit not active exactly three cycles");

    a_gate_fast:
    assert property (@(posedge clock) disable iff (rst)
        gate_q[GATE_FAST_TIMER_BIT] |=> !periphEn_q.fastTimer)
        else $error("gated fast timer still clocked");

    a_reserved_mode:
    assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_ACTIVE && sleepMode_q == SLEEP_MODE_RESERVED)
        |=> state_q == ST_ACTIVE)
        else $error("reserved mode entered sleep");
endmodule

/* File: dv/sleep_and_power_gating_ctrl_test.sv */
// self-checking testbench of the sleep and power gating controller
`timescale 1ns/1ps
module sleep_and_power_gating_ctrl_test
    import spg_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] busAddr = 8'h00;
    logic [7:0] busWrData = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic sleepInstr = 1'b0;
    spg_wake_s wakeReq = '0;
    logic adcEnabled = 1'b0;
    logic oscStable = 1'b1;
    logic [7:0] busRdData_q;
    spg_clk_s clkEn_q;
    spg_periph_s periphEn_q;
    logic bodEnable_q, adcStart_q, coreHalt_q, resumeIrq_q, resetVector_q;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] rdv;
    int n;

    spg_sleep_ctrl DUT (.clock(clock), .rst(rst), .busAddr(busAddr),
        .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .sleepInstr(sleepInstr), .wakeReq(wakeReq), .adcEnabled(adcEnabled),
        .oscStable(oscStable), .busRdData_q(busRdData_q), .clkEn_q(clkEn_q),
        .periphEn_q(periphEn_q), .bodEnable_q(bodEnable_q),
        .adcStart_q(adcStart_q), .coreHalt_q(coreHalt_q),
        .resumeIrq_q(resumeIrq_q), .resetVector_q(resetVector_q));

    initial begin
        forever #(CLOCK_PERIOD_NS / 2) clock = ~clock;
    end

    // ==========================================================
    // shared tasks
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // the longest test waits about 700 cycles, so 20000 is ample
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge clock);
        busWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clock);
        busRd <= 1'b0;
        #1 d = busRdData_q;
    endtask

    task automatic sleep();
        @(posedge clock);
        sleepInstr <= 1'b1;
        @(posedge clock);
        sleepInstr <= 1'b0;
        #1;
    endtask

    // holds the source until the core resumes, as a level source must
    task automatic wake(input spg_wake_s w, output int cnt);
        @(posedge clock);
        wakeReq <= w;
        cnt = 0;
        do begin
            @(posedge clock);
            #1 cnt++;
        end while (resumeIrq_q !== 1'b1 && cnt < 2000);
        wakeReq <= '0;
        chk({7'h0, coreHalt_q}, 8'h00);
        chk({2'h0, clkEn_q}, 8'h3F);
    endtask

    task automatic no_wake(input spg_wake_s w);
        @(posedge clock);
        wakeReq <= w;
        repeat (10) @(posedge clock);
        wakeReq <= '0;
        #1 chk({7'h0, coreHalt_q}, 8'h01);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_modes();
        logic [7:0] ctl[3] = '{8'h20, 8'h28, 8'h30};
        logic [7:0] clk[3] = '{8'h0F, 8'h05, 8'h00};
        spg_wake_s bad[3] = '{8'h00, 8'h02, 8'h06};
        spg_wake_s good[3] = '{8'h02, 8'h04, 8'h20};
        for (int m = 0; m < 3; m++) begin
            adcEnabled <= 1'b1;
            wr(CORE_CONTROL_REG_ADDR, ctl[m]);
            sleep();
            chk({7'h0, coreHalt_q}, 8'h01);
            chk({2'h0, clkEn_q}, clk[m]);
            chk({7'h0, adcStart_q}, {7'h0, m != 2});
            rd(SLEEP_STATUS_REG_ADDR, rdv);
            chk(rdv, 8'(m * 16 + 1));
            if (m > 0) no_wake(bad[m]);
            wake(good[m], n);
            chk(8'(n >= WAKE_HALT_CYCLES && n <= 8), 8'h01);
        end
        $display("test modes done");
    endtask

    task automatic t_refused();
        wr(CORE_CONTROL_REG_ADDR, 8'h38);
        sleep();
        chk({7'h0, coreHalt_q}, 8'h00);
        chk({2'h0, clkEn_q}, 8'h3F);
        wr(CORE_CONTROL_REG_ADDR, 8'h10);
        sleep();
        chk({7'h0, coreHalt_q}, 8'h00);
        $display("test refused done");
    endtask

    task automatic t_bod(input bit late);
        wr(CORE_CONTROL_REG_ADDR, 8'hB4);
        if (late) repeat (6) @(posedge clock);
        wr(CORE_CONTROL_REG_ADDR, 8'hB0);
        repeat (4) @(posedge clock);
        sleep();
        @(posedge clock);
        #1 chk({7'h0, bodEnable_q}, {7'h0, late});
        wake(8'h20, n);
        chk({7'h0, bodEnable_q}, 8'h01);
        if (!late) begin
            chk(8'(n >= RESET_WAKE_CYCLES + WAKE_HALT_CYCLES),
                8'h01);
        end
        rd(CORE_CONTROL_REG_ADDR, rdv);
        chk(rdv & 8'h80, 8'h00);
        $display("test brown-out sleep-off done");
    endtask

    task automatic t_gate();
        rd(MODULE_CLOCK_GATE_REG_ADDR, rdv);
        chk(rdv, 8'h00);
        // converter switched off before its clock is gated
        adcEnabled <= 1'b0;
        wr(MODULE_CLOCK_GATE_REG_ADDR, 8'h0F);
        @(posedge clock);
        #1 chk({4'h0, periphEn_q}, 8'h00);
        wr(MODULE_CLOCK_GATE_REG_ADDR, 8'h05);
        @(posedge clock);
        #1 chk({4'h0, periphEn_q}, 8'h0A);
        rd(MODULE_CLOCK_GATE_REG_ADDR, rdv);
        chk(rdv, 8'h05);
        wr(CORE_CONTROL_REG_ADDR, 8'h20);
        sleep();
        chk({4'h0, periphEn_q}, 8'h0A);
        wake(8'h01, n);
        wr(MODULE_CLOCK_GATE_REG_ADDR, 8'h00);
        @(posedge clock);
        #1 chk({4'h0, periphEn_q}, 8'h0F);
        rd(8'h7F, rdv);
        chk(rdv, 8'h00);
        $display("test gating done");
    endtask

    task automatic t_reset_sleep();
        wr(CORE_CONTROL_REG_ADDR, 8'h30);
        sleep();
        @(posedge clock);
        rst <= 1'b1;
        #1 chk({7'h0, resetVector_q}, 8'h01);
        chk({7'h0, coreHalt_q}, 8'h00);
        chk({2'h0, clkEn_q}, 8'h3F);
        @(posedge clock);
        rst <= 1'b0;
        rd(CORE_CONTROL_REG_ADDR, rdv);
        chk(rdv, 8'h00);
        $display("test reset in sleep done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (11) @(posedge clock);
        chk({2'h0, clkEn_q}, 8'h3F);
        chk({4'h0, periphEn_q}, 8'h0F);
        chk({6'h0, bodEnable_q, resetVector_q}, 8'h03);
        @(posedge clock);
        rst <= 1'b0;
        rd(CORE_CONTROL_REG_ADDR, rdv);
        chk(rdv, 8'h00);
        t_modes();
        t_refused();
        t_bod(1'b0);
        t_bod(1'b1);
        t_gate();
        t_reset_sleep();
        complete_run();
    end
endmodule
